// ===== rtl/serial_latch_load_port.v
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "serial_latch_load_port_map.vh"

module serial_latch_load_port (
	// Clock and reset
	input  wire                 clk_i,
	input  wire                 rst_n_i,
	// Serial link pins from the host
	input  wire                 serial_clk_i,
	input  wire                 serial_data_i,
	input  wire                 latch_load_strobe_i,
	input  wire                 chip_enable_i,
	// Internal status sources
	input  wire                 lock_detect_i,
	input  wire                 fb_scaled_i,
	input  wire                 ref_scaled_i,
	// Software register port
	input  wire [`ADDR_W-1:0]   addr_i,
	input  wire [`WORD_W-1:0]   wdata_i,
	input  wire                 wr_i,
	input  wire                 rd_i,
	output reg  [`WORD_W-1:0]   rdata_o,
	// Device outputs
	output reg  [`WORD_W-1:0]   control_latch_o,
	output reg  [`WORD_W-1:0]   ref_div_latch_o,
	output reg  [`WORD_W-1:0]   fb_div_latch_o,
	output reg                  powered_o,
	output reg                  charge_pump_output_oe_o,
	output reg                  monitor_output_select_o
);

	// Two-stage synchronisers for every pin; stage one is never looked at
	reg               sclk_s1_reg;
	reg               sclk_s2_reg;
	reg               sclk_d_reg;
	reg               sdat_s1_reg;
	reg               sdat_s2_reg;
	reg               load_s1_reg;
	reg               load_s2_reg;
	reg               load_d_reg;
	reg               ce_s1_reg;
	reg               ce_s2_reg;
	reg               lock_s1_reg;
	reg               lock_s2_reg;
	reg               fb_s1_reg;
	reg               fb_s2_reg;
	reg               ref_s1_reg;
	reg               ref_s2_reg;
	// Word path and load bookkeeping
	reg [`WORD_W-1:0] shift_reg;
	reg [`WORD_W-1:0] test_latch_reg;
	reg [`CNT_W-1:0]  load_cnt_reg;
	// Combinational next values
	reg               mon_next;
	reg [`WORD_W-1:0] rdata_next;
	wire              sclk_rise;
	wire              load_rise;
	wire              pd_ok;
	wire [1:0]        sel;

	// Rising edge of a synchronised level against its copy one cycle older
	function rise_of;
		input cur_lvl;
		input old_lvl;
		begin
			rise_of = cur_lvl & ~old_lvl;
		end
	endfunction

	// Synchroniser chains; every stage resets to the idle low level of its pin,
	// so no false edge is seen right after reset
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_d_reg  <= 1'b0;
			sdat_s1_reg <= 1'b0;
			sdat_s2_reg <= 1'b0;
			load_s1_reg <= 1'b0;
			load_s2_reg <= 1'b0;
			load_d_reg  <= 1'b0;
			ce_s1_reg   <= 1'b0;
			ce_s2_reg   <= 1'b0;
			lock_s1_reg <= 1'b0;
			lock_s2_reg <= 1'b0;
			fb_s1_reg   <= 1'b0;
			fb_s2_reg   <= 1'b0;
			ref_s1_reg  <= 1'b0;
			ref_s2_reg  <= 1'b0;
		end else begin
			sclk_s1_reg <= serial_clk_i;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_d_reg  <= sclk_s2_reg;
			sdat_s1_reg <= serial_data_i;
			sdat_s2_reg <= sdat_s1_reg;
			load_s1_reg <= latch_load_strobe_i;
			load_s2_reg <= load_s1_reg;
			load_d_reg  <= load_s2_reg;
			ce_s1_reg   <= chip_enable_i;
			ce_s2_reg   <= ce_s1_reg;
			lock_s1_reg <= lock_detect_i;
			lock_s2_reg <= lock_s1_reg;
			fb_s1_reg   <= fb_scaled_i;
			fb_s2_reg   <= fb_s1_reg;
			ref_s1_reg  <= ref_scaled_i;
			ref_s2_reg  <= ref_s1_reg;
		end
	end

	// Edge detection on synchronised copies; data and clock share latency
	assign sclk_rise = rise_of(sclk_s2_reg, sclk_d_reg);
	assign load_rise = rise_of(load_s2_reg, load_d_reg);
	assign sel       = shift_reg[`SEL_HI:`SEL_LO];
	assign pd_ok     = (control_latch_o[`PD_BIT_HI:`PD_BIT_LO] == `PD_ACTIVE);

	// Shift register, MSB first: new bit enters at bit 0 and moves up
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			shift_reg <= `ZERO_WORD;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[`WORD_W-2:0], sdat_s2_reg};
		end
	end

	// One latch per strobe rising edge; software may also write the latches, except the test latch
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			control_latch_o <= `ZERO_WORD;
			ref_div_latch_o <= `ZERO_WORD;
			fb_div_latch_o  <= `ZERO_WORD;
			test_latch_reg  <= `ZERO_WORD;
			load_cnt_reg    <= `ZERO_CNT;
		end else if (load_rise) begin
			// One update per strobe edge; a level held high loads nothing more
			load_cnt_reg <= load_cnt_reg + `CNT_STEP;
			case (sel)
			`SEL_CONTROL: begin
				control_latch_o <= shift_reg;
			end
			`SEL_REF_DIV: begin
				ref_div_latch_o <= shift_reg;
			end
			`SEL_FB_DIV: begin
				fb_div_latch_o <= shift_reg;
			end
			default: begin
				test_latch_reg <= shift_reg; // kept only for readback
			end
			endcase
		end else if (wr_i) begin
			// Serial load has priority so a host word is never lost
			case (addr_i)
			`ADDR_CONTROL: begin
				control_latch_o <= wdata_i;
			end
			`ADDR_REF_DIV: begin
				ref_div_latch_o <= wdata_i;
			end
			`ADDR_FB_DIV: begin
				fb_div_latch_o <= wdata_i;
			end
			default: begin
				load_cnt_reg <= load_cnt_reg;
			end
			endcase
		end
	end

	// Monitor multiplexer; the output stage below holds it low while chip enable is low
	always @* begin
		case (control_latch_o[`MON_HI:`MON_LO])
		`MON_LOCK: mon_next = lock_s2_reg;
		`MON_FB:   mon_next = fb_s2_reg;
		`MON_REF:  mon_next = ref_s2_reg;
		default:   mon_next = 1'b0;
		endcase
	end

	// Register read mux; unmapped addresses read zero
	always @* begin
		case (addr_i)
		`ADDR_CONTROL: rdata_next = control_latch_o;
		`ADDR_REF_DIV: rdata_next = ref_div_latch_o;
		`ADDR_FB_DIV:  rdata_next = fb_div_latch_o;
		`ADDR_TEST:    rdata_next = test_latch_reg;
		`ADDR_STATUS:  rdata_next = {21'h000000, ce_s2_reg, charge_pump_output_oe_o,
		                             powered_o};
		`ADDR_LOADS:   rdata_next = {16'h0000, load_cnt_reg};
		default:       rdata_next = `ZERO_WORD;
		endcase
	end

	// Power state, pump enable and registered outputs
	// Pump enable shares the power gate, so the pump never drives while asleep
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			powered_o               <= 1'b0;
			charge_pump_output_oe_o <= 1'b0;
			monitor_output_select_o <= 1'b0;
			rdata_o                 <= `ZERO_WORD;
		end else begin
			powered_o               <= ce_s2_reg & pd_ok;
			charge_pump_output_oe_o <= ce_s2_reg & pd_ok;
			monitor_output_select_o <= ce_s2_reg & mon_next;
			rdata_o                 <= rd_i ? rdata_next : `ZERO_WORD;
		end
	end

endmodule

// ===== rtl/serial_latch_load_port_map.vh
`ifndef SERIAL_LATCH_LOAD_PORT_MAP_VH
`define SERIAL_LATCH_LOAD_PORT_MAP_VH

// Word and latch-select layout
`define WORD_W          24
`define SEL_HI          1
`define SEL_LO          0
`define SEL_CONTROL     2'h0
`define SEL_REF_DIV     2'h1
`define SEL_FB_DIV      2'h2
`define SEL_TEST        2'h3

// Power-down field in the control latch
`define PD_BIT_HI       21
`define PD_BIT_LO       20
`define PD_ACTIVE       2'h0

// Monitor select field in the control latch
`define MON_HI          7
`define MON_LO          5
`define MON_W           3
`define MON_OFF         3'h0
`define MON_LOCK        3'h1
`define MON_FB          3'h2
`define MON_REF         3'h4

// Register map on the software port
`define ADDR_W          3
`define ADDR_CONTROL    3'h0
`define ADDR_REF_DIV    3'h1
`define ADDR_FB_DIV     3'h2
`define ADDR_TEST       3'h3
`define ADDR_STATUS     3'h4
`define ADDR_LOADS      3'h5

// Status word bit positions
`define ST_POWERED      0
`define ST_CP_EN        1
`define ST_CHIP_EN      2

// Reset values
`define ZERO_WORD       24'h000000
`define ZERO_CNT        8'h00

// Serial load counter
`define CNT_W           8
`define CNT_STEP        8'h01

`endif

// ===== sim/serial_latch_load_port_sva.sv
`timescale 1ns/1ns
module slp_sva (
	input logic        clk_i,
	input logic        rst_n_i,
	input logic        chip_enable_i,
	input logic        lock_detect_i,
	input logic [23:0] control_latch_o,
	input logic [23:0] ref_div_latch_o,
	input logic [23:0] fb_div_latch_o,
	input logic        powered_o,
	input logic        charge_pump_output_oe_o,
	input logic        monitor_output_select_o
);
	// Single domain; pin paths pass a synchroniser, so inputs are held a few cycles
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_PD_OFF: assert property (!chip_enable_i [*4] |-> !powered_o)
		else $error("powered with chip enable low");
	AST_CP_Z: assert property (!chip_enable_i [*4] |-> !charge_pump_output_oe_o)
		else $error("pump driven with chip enable low");
	AST_PWR_ON: assert property ((chip_enable_i && control_latch_o[21:20] == 2'h0) [*5]
		|-> powered_o && charge_pump_output_oe_o) else $error("not powered up");
	AST_PWR_BITS: assert property ((control_latch_o[21:20] != 2'h0) [*2] |-> !powered_o)
		else $error("powered against power-down bits");
	AST_MON_OFF: assert property (!chip_enable_i [*4] |-> !monitor_output_select_o)
		else $error("monitor active while off");
	AST_MON_LOCK: assert property ((chip_enable_i && lock_detect_i
		&& control_latch_o[7:5] == 3'h1) [*5] |-> monitor_output_select_o)
		else $error("monitor misses lock");
	AST_ONE_REF: assert property ($changed(ref_div_latch_o)
		|-> $stable(control_latch_o) && $stable(fb_div_latch_o)) else $error("two latches");
	AST_ONE_FB: assert property ($changed(fb_div_latch_o)
		|-> $stable(control_latch_o) && $stable(ref_div_latch_o)) else $error("two latches");
endmodule
bind serial_latch_load_port slp_sva u_sva (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_enable_i(chip_enable_i),
	.lock_detect_i(lock_detect_i), .control_latch_o(control_latch_o),
	.ref_div_latch_o(ref_div_latch_o), .fb_div_latch_o(fb_div_latch_o),
	.powered_o(powered_o), .charge_pump_output_oe_o(charge_pump_output_oe_o),
	.monitor_output_select_o(monitor_output_select_o));

// ===== sim/host_model.sv
`timescale 1ns/1ns
module host_model (
	output logic sclk = 1'b0,
	output logic sdata = 1'b0,
	output logic load_strobe = 1'b0
);
	// One word, top bit first; clock idles low between frames
	task automatic send(input logic [23:0] w);
		#1;
		for (int i = 23; i >= 0; i--) begin
			sdata = w[i];
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		#40 load_strobe = 1'b1;
		#40 load_strobe = 1'b0;
		sdata = ~w[0]; // Released line must not echo the last bit
		#40;
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ns
`include "serial_latch_load_port_map.vh"
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        chip_enable_i = 1'b0;
	logic        lock_detect_i = 1'b0, fb_scaled_i = 1'b0, ref_scaled_i = 1'b0;
	logic [2:0]  addr_i = 3'h0;
	logic [23:0] wdata_i = 24'h000000;
	logic        wr_i = 1'b0, rd_i = 1'b0;
	logic        serial_clk_i, serial_data_i, latch_load_strobe_i;
	logic [23:0] rdata_o, control_latch_o, ref_div_latch_o, fb_div_latch_o;
	logic        powered_o, charge_pump_output_oe_o, monitor_output_select_o;
	int          err_count = 0;
	int          n_tests = 0;
	wire  [23:0] outs = {21'h0, powered_o, charge_pump_output_oe_o, monitor_output_select_o};
	host_model host (.sclk(serial_clk_i), .sdata(serial_data_i),
		.load_strobe(latch_load_strobe_i));
	serial_latch_load_port uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i),
		.serial_data_i(serial_data_i), .latch_load_strobe_i(latch_load_strobe_i),
		.chip_enable_i(chip_enable_i), .lock_detect_i(lock_detect_i),
		.fb_scaled_i(fb_scaled_i), .ref_scaled_i(ref_scaled_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.control_latch_o(control_latch_o), .ref_div_latch_o(ref_div_latch_o),
		.fb_div_latch_o(fb_div_latch_o), .powered_o(powered_o),
		.charge_pump_output_oe_o(charge_pump_output_oe_o),
		.monitor_output_select_o(monitor_output_select_o));
	// Clock and a watchdog so nothing hangs
	initial forever #2 clk_i = ~clk_i;
	initial begin
		#100000 err_count++;
		stop_test();
	end
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bus tasks start right after a rising edge
	task automatic wr(input logic [2:0] a, input logic [23:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input string n, input logic [2:0] a, input logic [23:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(n, e, rdata_o);
		@(posedge clk_i);
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd("ctl", `ADDR_CONTROL, 24'h000000);
		rd("sta", `ADDR_STATUS, 24'h000000);
		$display("test reset done");
		chip_enable_i <= 1'b1;
		host.send(24'h5A3C81);
		chk("ctl", 24'h000000, control_latch_o);
		host.send(24'h8F0E20);
		host.send(24'hC3A5F2);
		@(posedge clk_i);
		chk("ref", 24'h5A3C81, ref_div_latch_o);
		chk("ctl", 24'h8F0E20, control_latch_o);
		chk("fb", 24'hC3A5F2, fb_div_latch_o);
		chk("out", 24'h000006, outs);
		rd("cnt", `ADDR_LOADS, 24'h000003);
		$display("test serial done");
		for (int i = 0; i < 3; i++) begin
			wr(`ADDR_CONTROL, {16'h8F0E, 3'h1 << i, 5'h00});
			{lock_detect_i, fb_scaled_i, ref_scaled_i} <= 3'h4 >> i;
			repeat (6) @(posedge clk_i);
			chk("mon", 24'h000007, outs);
			{lock_detect_i, fb_scaled_i, ref_scaled_i} <= ~(3'h4 >> i);
			repeat (6) @(posedge clk_i);
			chk("mon", 24'h000006, outs);
		end
		$display("test monitor done");
		{lock_detect_i, fb_scaled_i, ref_scaled_i} <= 3'h7;
		chip_enable_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("out", 24'h000000, outs);
		wr(`ADDR_CONTROL, 24'h9F0E20);
		chip_enable_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd("sta", `ADDR_STATUS, 24'h000004);
		wr(`ADDR_TEST, 24'hFFFFFF);
		wr(3'h6, 24'h123456);
		rd("tst", `ADDR_TEST, 24'h000000);
		rd("ctl", `ADDR_CONTROL, 24'h9F0E20);
		wr(`ADDR_CONTROL, 24'h8F0E00);
		repeat (6) @(posedge clk_i);
		chk("mon", 24'h000006, outs);
		$display("test power done");
		stop_test();
	end
endmodule
